//--- design/clk_source_switch.sv
// glitch-free selection among four source ticks
`timescale 1ns/1ns
module clk_source_switch (
  input  wire logic i_sys_clk,
  input  wire logic i_nrst,
  src_tick_if.sw    link
);
  logic [1:0] cur;
  logic       gate;

  // close on an old-source tick, reopen on a new-source tick
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      cur           <= 2'h0;
      gate          <= 1'b1;
      link.switched <= 1'b0;
    end else begin
      link.switched <= 1'b0;
      if (gate && link.sel != cur && link.tick[cur]) begin
        gate <= 1'b0;             // last whole old tick passes
      end else if (!gate && link.sel != cur) begin
        cur <= link.sel;          // follow late selection changes
      end else if (!gate && link.tick[cur]) begin
        gate          <= 1'b1;    // first whole new tick opens
        link.switched <= 1'b1;
      end
    end
  end

  // only whole ticks of the current source leave
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      link.hf_tick <= 1'b0;
    end else begin
      link.hf_tick <= gate && link.tick[cur];
    end
  end
endmodule : clk_source_switch

//--- design/periph_divider.sv
// integer or fractional divider of the system clock tick
`timescale 1ns/1ns
module periph_divider #(
  parameter int W    = 16,
  parameter int FW   = 5,
  parameter bit FRAC = 1'b0
) (
  input  wire logic          i_sys_clk,
  input  wire logic          i_nrst,
  input  wire logic          i_tick,
  input  wire logic          i_en,
  input  wire logic [W-1:0]  i_int,
  input  wire logic [FW-1:0] i_frac,
  output logic               o_tick
);
  logic [W-1:0]  cnt;
  logic [FW-1:0] acc;
  logic          stretch;
  logic [FW:0]   acc_sum;

  if (W < 2 || FW < 1) begin : g_bad_width
    $error("periph_divider: unsupported width");
  end

  // fraction accumulator carry adds one input tick
  assign acc_sum = {1'b0, acc} + {1'b0, (FRAC ? i_frac : {FW{1'b0}})};

  // period is i_int+1 input ticks, plus the carried stretch
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      cnt     <= '0;
      acc     <= '0;
      stretch <= 1'b0;
      o_tick  <= 1'b0;
    end else if (!i_en) begin
      cnt     <= '0;
      acc     <= '0;
      stretch <= 1'b0;
      o_tick  <= 1'b0;
    end else begin
      o_tick <= 1'b0;
      if (i_tick) begin
        if ({1'b0, cnt} >= {1'b0, i_int} + {{W{1'b0}}, stretch}) begin
          cnt     <= '0;
          o_tick  <= 1'b1;
          acc     <= acc_sum[FW-1:0];
          stretch <= acc_sum[FW];
        end else begin
          cnt <= cnt + 1'b1;
        end
      end
    end
  end
endmodule : periph_divider

//--- design/pwr_clk_ctrl.sv
// power modes, clock sources, peripheral dividers and supervision timer
`timescale 1ns/1ns
// Operation
// - Active, Sleep and Deep Sleep modes exist and Active clocks every subsystem.
// - Sleep gates the CPU, flash and SRAM clock, keeps peripherals and wakes at once.
// - Deep Sleep stops the system clock and its oscillator, and waking takes 35 us.
// - No mode is entered before supply is good, and a brown-out raises a reset.
// - Source changes give no runt tick and pins are synchronised first.
// - Sources are main oscillator, slow oscillator, watch crystal and external clock.
// - The main oscillator is 24 MHz after reset, settable 24 to 48 MHz in 4 MHz steps.
// - Eight 16-bit dividers of the system clock, two of them fractional.
// - The slow oscillator of about 40 kHz clocks the timer and deep-sleep peripherals.
// - The supervision timer counts slow ticks, also in Deep Sleep, and resets on timeout.
// - A supervision timeout is recorded in a readable reset-cause register.
// - The reset-cause record survives the reset it describes.
module pwr_clk_ctrl
  import pwr_clk_pkg::*;
#(
  parameter int NUM_DIV  = N_DIV,
  parameter int NUM_FRAC = N_FRAC_DIV
) (
  input  wire logic               i_sys_clk,
  input  wire logic               i_nrst,
  input  wire logic               i_por_nrst,
  input  wire logic [7:0]         i_avs_address,
  input  wire logic               i_avs_read,
  input  wire logic               i_avs_write,
  input  wire logic [31:0]        i_avs_writedata,
  output logic      [31:0]        o_avs_readdata,
  output logic                    o_avs_waitrequest,
  input  wire logic               i_main_osc,
  input  wire logic               i_slow_osc,
  input  wire logic               i_watch_osc,
  input  wire logic               i_ext_clk,
  input  wire logic               i_supply_ok,
  input  wire logic               i_brownout,
  input  wire logic               i_wake_event,
  output logic                    o_hf_tick,
  output logic                    o_lf_tick,
  output logic                    o_cpu_clk_en,
  output logic                    o_periph_clk_en,
  output logic                    o_main_osc_en,
  output logic      [2:0]         o_main_osc_freq,
  output logic      [NUM_DIV-1:0] o_periph_tick,
  output logic      [1:0]         o_power_mode,
  output logic                    o_chip_reset,
  output logic                    o_irq
);
  if (NUM_DIV < 1 || NUM_DIV > 8 || NUM_FRAC > NUM_DIV) begin : g_bad_cfg
    $error("pwr_clk_ctrl: unsupported divider count");
  end

  // byte address falls on a configured divider word
  function automatic logic is_div(input logic [7:0] a);
    return (a >= ADDR_DIV_BASE) && (a < ADDR_DIV_BASE + 8'(4 * NUM_DIV)) && (a[1:0] == 2'h0);
  endfunction : is_div

  // divider index of a divider address
  function automatic logic [2:0] div_idx(input logic [7:0] a);
    return a[4:2];
  endfunction : div_idx

  logic [6:0]                 pin_a;
  logic [6:0]                 pin_b;
  logic [3:0]                 pin_c;
  logic [3:0]                 src_tick;
  logic                       supply_ok;
  logic                       bod_s;
  logic                       bod_d;
  logic                       bod_evt;
  logic                       wake_s;
  logic                       rd_go;
  logic                       wr_go;
  logic [31:0]                rd_value;
  logic [1:0]                 mode_code;
  logic                       mode_go;
  logic [1:0]                 clk_sel;
  logic [2:0]                 main_freq;
  logic                       sup_en;
  logic [15:0]                sup_match;
  logic [15:0]                sup_cnt;
  logic                       sup_fire;
  logic                       sup_warn;
  logic                       service;
  logic [CAUSE_W-1:0]         cause;
  logic [INT_W-1:0]           int_stat;
  logic [INT_W-1:0]           int_mask;
  logic [INT_W-1:0]           int_set;
  logic [INT_W-1:0]           int_clr;
  logic [31:0]                div_cfg [NUM_DIV];
  pwr_state_t                 state;
  pwr_state_t                 next_state;
  logic [WAKE_CNT_W-1:0]      wake_cnt;
  logic                       wake_evt;
  logic                       wake_done;
  logic                       hf_run;
  src_tick_if                 tick_bus ();

  // two-flop synchronisers, third stage only for source edges
  // pins synchronised first
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      pin_a <= '0;
      pin_b <= '0;
      pin_c <= '0;
    end else begin
      pin_a <= {i_wake_event, i_brownout, i_supply_ok,
                i_ext_clk, i_watch_osc, i_slow_osc, i_main_osc};
      pin_b <= pin_a;
      pin_c <= pin_b[3:0];
    end
  end

  // four source ticks on rising edges
  assign src_tick  = pin_b[3:0] & ~pin_c;
  assign supply_ok = pin_b[4];
  assign bod_s     = pin_b[5];
  assign wake_s    = pin_b[6];
  assign bod_evt   = bod_s && !bod_d;

  // brown-out edge memory
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      bod_d <= 1'b0;
    end else begin
      bod_d <= bod_s;
    end
  end

  // glitch-free source selection
  assign tick_bus.tick = src_tick;
  assign tick_bus.sel  = clk_sel;

  clk_source_switch u_switch (
    .i_sys_clk (i_sys_clk),
    .i_nrst    (i_nrst),
    .link      (tick_bus.sw)
  );

  // avalon handshake: one wait cycle, then the request is taken
  assign rd_go = i_avs_read && !o_avs_waitrequest;
  assign wr_go = i_avs_write && !o_avs_waitrequest;

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_avs_waitrequest <= 1'b1;
      o_avs_readdata    <= '0;
    end else if ((i_avs_read || i_avs_write) && o_avs_waitrequest) begin
      o_avs_waitrequest <= 1'b0;
      o_avs_readdata    <= i_avs_read ? rd_value : 32'h0000_0000;
    end else begin
      o_avs_waitrequest <= 1'b1;
    end
  end

  // register read mux, unmapped addresses read zero
  always_comb begin
    rd_value = '0;
    case (i_avs_address)
      ADDR_PWR_CTRL:  rd_value[1:0] = mode_code;
      ADDR_PWR_STAT: begin
        rd_value[1:0] = o_power_mode;
        rd_value[2]   = supply_ok;
      end
      ADDR_CLK_SEL:   rd_value[1:0] = clk_sel;
      ADDR_MAIN_FREQ: rd_value[2:0] = main_freq;
      ADDR_SUP_CTRL:  rd_value[0] = sup_en;
      ADDR_SUP_MATCH: rd_value[15:0] = sup_match;
      ADDR_SUP_SERVICE: rd_value[15:0] = sup_cnt;
      ADDR_RST_CAUSE: rd_value[CAUSE_W-1:0] = cause;
      ADDR_INT_STAT:  rd_value[INT_W-1:0] = int_stat;
      ADDR_INT_MASK:  rd_value[INT_W-1:0] = int_mask;
      default: begin
        if (is_div(i_avs_address)) begin
          rd_value = div_cfg[div_idx(i_avs_address)];
        end
      end
    endcase
  end

  // control registers written by software
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      mode_code <= MODE_ACTIVE;
      mode_go   <= 1'b0;
      clk_sel   <= CLK_SEL_RST;
      main_freq <= MAIN_FREQ_RST;
      sup_en    <= SUP_EN_RST;
      sup_match <= SUP_MATCH_RST;
      int_mask  <= INT_MASK_RST;
    end else begin
      mode_go <= 1'b0;
      if (wr_go) begin
        case (i_avs_address)
          ADDR_PWR_CTRL: begin
            mode_code <= i_avs_writedata[1:0];
            mode_go   <= 1'b1;
          end
          ADDR_CLK_SEL:   clk_sel <= i_avs_writedata[1:0];
          // main oscillator 24 MHz plus 4 MHz per step
          ADDR_MAIN_FREQ: begin
            if (i_avs_writedata[2:0] <= MAIN_FREQ_MAX) begin
              main_freq <= i_avs_writedata[2:0];
            end
          end
          ADDR_SUP_CTRL:  sup_en <= i_avs_writedata[0];
          ADDR_SUP_MATCH: sup_match <= i_avs_writedata[15:0];
          ADDR_INT_MASK:  int_mask <= i_avs_writedata[INT_W-1:0];
          default: ;
        endcase
      end
    end
  end

  // eight dividers, the first ones fractional
  for (genvar k = 0; k < NUM_DIV; k++) begin : g_div
    localparam bit IS_FRAC = (k < NUM_FRAC);

    always_ff @(posedge i_sys_clk or negedge i_nrst) begin
      if (!i_nrst) begin
        div_cfg[k] <= '0;
      end else if (wr_go && is_div(i_avs_address) && div_idx(i_avs_address) == 3'(k)) begin
        div_cfg[k]                                 <= '0;
        div_cfg[k][DIV_EN_BIT]                     <= i_avs_writedata[DIV_EN_BIT];
        div_cfg[k][DIV_INT_LSB +: DIV_W]           <= i_avs_writedata[DIV_INT_LSB +: DIV_W];
        if (IS_FRAC) begin
          div_cfg[k][DIV_FRAC_LSB +: FRAC_W] <= i_avs_writedata[DIV_FRAC_LSB +: FRAC_W];
        end
      end
    end

    periph_divider #(
      .W    (DIV_W),
      .FW   (FRAC_W),
      .FRAC (IS_FRAC)
    ) u_div (
      .i_sys_clk (i_sys_clk),
      .i_nrst    (i_nrst),
      .i_tick    (o_hf_tick),
      .i_en      (div_cfg[k][DIV_EN_BIT]),
      .i_int     (div_cfg[k][DIV_INT_LSB +: DIV_W]),
      .i_frac    (div_cfg[k][DIV_FRAC_LSB +: FRAC_W]),
      .o_tick    (o_periph_tick[k])
    );
  end

  // wake sources: wake pin or any unmasked pending interrupt
  assign wake_evt = wake_s || (|(int_stat & int_mask));

  // power mode sequencing
  always_comb begin
    next_state = state;
    case (state)
      ST_POWERUP: if (supply_ok) next_state = ST_ACTIVE;
      ST_ACTIVE: begin
        if (mode_go && mode_code == MODE_SLEEP) begin
          next_state = ST_SLEEP;
        end else if (mode_go && mode_code == MODE_DEEP) begin
          next_state = ST_DEEP;
        end
      end
      ST_SLEEP: if (wake_evt) next_state = ST_ACTIVE;
      ST_DEEP:  if (wake_evt) next_state = ST_WAKE;
      ST_WAKE:  if (wake_cnt == WAKE_CNT_W'(WAKE_CYC - 1)) next_state = ST_ACTIVE;
      default:  next_state = ST_POWERUP;
    endcase
    if (!supply_ok || bod_s) next_state = ST_POWERUP;
  end

  assign wake_done = (next_state == ST_ACTIVE) && (state == ST_SLEEP || state == ST_WAKE);

  // state and wake-up counter
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state    <= ST_POWERUP;
      wake_cnt <= '0;
    end else begin
      state    <= next_state;
      wake_cnt <= (state == ST_WAKE) ? wake_cnt + 1'b1 : '0;
    end
  end

  assign hf_run = (next_state == ST_ACTIVE) || (next_state == ST_SLEEP);  // aligned with mode

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_cpu_clk_en    <= 1'b0;
      o_periph_clk_en <= 1'b0;
      o_main_osc_en   <= 1'b0;
      o_power_mode    <= MODE_ACTIVE;
      o_main_osc_freq <= MAIN_FREQ_RST;
    end else begin
      o_cpu_clk_en    <= (next_state == ST_ACTIVE);
      o_periph_clk_en <= (next_state == ST_ACTIVE) || (next_state == ST_SLEEP);
      o_main_osc_en   <= (next_state != ST_DEEP) && (next_state != ST_POWERUP);
      o_main_osc_freq <= main_freq;
      case (next_state)
        ST_SLEEP: o_power_mode <= MODE_SLEEP;
        ST_DEEP:  o_power_mode <= MODE_DEEP;
        ST_WAKE:  o_power_mode <= MODE_WAKING;
        default:  o_power_mode <= MODE_ACTIVE;
      endcase
    end
  end

  // system tick stopped outside active and sleep
  // slow tick runs in every mode
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_hf_tick <= 1'b0;
      o_lf_tick <= 1'b0;
    end else begin
      o_hf_tick <= tick_bus.hf_tick && hf_run;
      o_lf_tick <= src_tick[SRC_SLOW];
    end
  end

  assign service = wr_go && (i_avs_address == ADDR_SUP_SERVICE) && (i_avs_writedata == SUP_KEY);

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      sup_cnt  <= '0;
      sup_fire <= 1'b0;
      sup_warn <= 1'b0;
    end else begin
      sup_fire <= 1'b0;
      sup_warn <= 1'b0;
      if (service || !sup_en) begin
        sup_cnt <= '0;
      end else if (src_tick[SRC_SLOW]) begin
        if (sup_cnt >= sup_match) begin
          sup_fire <= 1'b1;
          sup_cnt  <= '0;
        end else begin
          sup_cnt <= sup_cnt + 1'b1;
        end
        if (sup_cnt == (sup_match >> 1)) begin
          sup_warn <= 1'b1;            // half-way warning
        end
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_chip_reset <= 1'b0;
    end else begin
      o_chip_reset <= sup_fire || bod_evt;
    end
  end

  // cause record, write one to clear, set wins
  always_ff @(posedge i_sys_clk or negedge i_por_nrst) begin
    if (!i_por_nrst) begin
      cause <= '0;
    end else begin
      if (wr_go && i_avs_address == ADDR_RST_CAUSE) begin
        cause <= cause & ~i_avs_writedata[CAUSE_W-1:0];
      end
      if (sup_fire) cause[CAUSE_SUP] <= 1'b1;
      if (bod_evt)  cause[CAUSE_BOD] <= 1'b1;
    end
  end

  // sticky events, read clears only what was returned
  always_comb begin
    int_set               = '0;
    int_set[INT_WAKE]     = wake_done;
    int_set[INT_SUP_WARN] = sup_warn;
    int_set[INT_CLK_SW]   = tick_bus.switched;
    int_set[INT_BROWNOUT] = bod_evt;
    int_clr = (rd_go && i_avs_address == ADDR_INT_STAT) ? o_avs_readdata[INT_W-1:0] : '0;
  end

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      int_stat <= '0;
      o_irq    <= 1'b0;
    end else begin
      int_stat <= (int_stat & ~int_clr) | int_set;
      o_irq    <= |(((int_stat & ~int_clr) | int_set) & int_mask);
    end
  end
endmodule : pwr_clk_ctrl

//--- pkg/pwr_clk_pkg.sv
// constants and types of the power, clock and supervision controller
package pwr_clk_pkg;
  // system clock and wake-up timing
  localparam int SYS_CLK_HZ   = 20_000_000;
  localparam int WAKE_TIME_US = 35;
  localparam int WAKE_CYC     = (WAKE_TIME_US * SYS_CLK_HZ + 999_999) / 1_000_000;
  localparam int WAKE_CNT_W   = $clog2(WAKE_CYC);

  // register byte offsets
  localparam logic [7:0] ADDR_PWR_CTRL    = 8'h00;
  localparam logic [7:0] ADDR_PWR_STAT    = 8'h04;
  localparam logic [7:0] ADDR_CLK_SEL     = 8'h08;
  localparam logic [7:0] ADDR_MAIN_FREQ   = 8'h0C;
  localparam logic [7:0] ADDR_SUP_CTRL    = 8'h10;
  localparam logic [7:0] ADDR_SUP_MATCH   = 8'h14;
  localparam logic [7:0] ADDR_SUP_SERVICE = 8'h18;
  localparam logic [7:0] ADDR_RST_CAUSE   = 8'h1C;
  localparam logic [7:0] ADDR_INT_STAT    = 8'h20;
  localparam logic [7:0] ADDR_INT_MASK    = 8'h24;
  localparam logic [7:0] ADDR_DIV_BASE    = 8'h40;

  // divider configuration word layout
  localparam int N_DIV        = 8;
  localparam int N_FRAC_DIV   = 2;
  localparam int DIV_W        = 16;
  localparam int FRAC_W       = 5;
  localparam int DIV_INT_LSB  = 0;
  localparam int DIV_FRAC_LSB = 16;
  localparam int DIV_EN_BIT   = 31;

  // interrupt status / mask bits
  localparam int INT_W        = 4;
  localparam int INT_WAKE     = 0;
  localparam int INT_SUP_WARN = 1;
  localparam int INT_CLK_SW   = 2;
  localparam int INT_BROWNOUT = 3;

  // reset cause bits
  localparam int CAUSE_W   = 2;
  localparam int CAUSE_SUP = 0;
  localparam int CAUSE_BOD = 1;

  // power mode request codes, also the reported mode, MODE_WAKING only reported
  localparam logic [1:0] MODE_ACTIVE = 2'h0;
  localparam logic [1:0] MODE_SLEEP  = 2'h1;
  localparam logic [1:0] MODE_DEEP   = 2'h2;
  localparam logic [1:0] MODE_WAKING = 2'h3;

  // clock source codes, also the index of each source tick
  localparam logic [1:0] SRC_MAIN  = 2'h0;
  localparam logic [1:0] SRC_SLOW  = 2'h1;
  localparam logic [1:0] SRC_WATCH = 2'h2;
  localparam logic [1:0] SRC_EXT   = 2'h3;

  // reset values, highest frequency code and service key
  localparam logic [1:0]  CLK_SEL_RST    = SRC_MAIN;
  localparam logic [2:0]  MAIN_FREQ_RST  = 3'h0;
  localparam logic [2:0]  MAIN_FREQ_MAX  = 3'h6;
  localparam logic        SUP_EN_RST     = 1'b1;
  localparam logic [15:0] SUP_MATCH_RST  = 16'h0FA0;
  localparam logic [31:0] SUP_KEY        = 32'h0000_ACED;
  localparam logic [3:0]  INT_MASK_RST   = 4'h0;

  typedef enum {ST_POWERUP, ST_ACTIVE, ST_SLEEP, ST_DEEP, ST_WAKE} pwr_state_t;
endpackage : pwr_clk_pkg

//--- pkg/src_tick_if.sv
// source ticks and selection between controller and clock switch
`timescale 1ns/1ns
interface src_tick_if;
  logic [3:0] tick;
  logic [1:0] sel;
  logic       hf_tick;
  logic       switched;
  modport ctrl (output tick, output sel, input hf_tick, input switched);
  modport sw   (input tick, input sel, output hf_tick, output switched);
endinterface : src_tick_if

//--- tb/power_clock_watchdog_ctrl_test.sv
// self-checking bench of the power, clock and supervision controller
`timescale 1ns/1ns
module power_clock_watchdog_ctrl_test
  import pwr_clk_pkg::*;
;
  logic        clk = 1'b0, nrst = 1'b0, por_nrst = 1'b0, rd = 1'b0, wr = 1'b0;
  logic        supply_ok = 1'b1, brownout = 1'b0, wake = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000, q, o_rd;
  logic        wreq, hf, lf, cpu_en, per_en, osc_en, chip_rst, irq, m_o, s_o, w_o, e_o;
  logic [2:0]  freq;
  logic [7:0]  ptick;
  logic [1:0]  mode;
  int          n_errors = 0, check_count = 0, n_rst = 0, nh, np, nl, n, d;
  logic [7:0]  row_a [7] = '{ADDR_CLK_SEL, ADDR_MAIN_FREQ, ADDR_SUP_CTRL, ADDR_SUP_MATCH,
                             ADDR_INT_MASK, ADDR_PWR_STAT, 8'h30};
  logic [31:0] row_d [7] = '{32'(CLK_SEL_RST), 32'(MAIN_FREQ_RST), 32'(SUP_EN_RST),
                             32'(SUP_MATCH_RST), 32'(INT_MASK_RST), 32'h0000_0004, 32'h0000_0000};
  pwr_clk_ctrl dut_u (.i_sys_clk(clk), .i_nrst(nrst), .i_por_nrst(por_nrst), .i_avs_address(addr),
    .i_avs_read(rd), .i_avs_write(wr), .i_avs_writedata(wdata), .o_avs_readdata(o_rd),
    .o_avs_waitrequest(wreq), .i_main_osc(m_o), .i_slow_osc(s_o), .i_watch_osc(w_o),
    .i_ext_clk(e_o), .i_supply_ok(supply_ok), .i_brownout(brownout), .i_wake_event(wake),
    .o_hf_tick(hf), .o_lf_tick(lf), .o_cpu_clk_en(cpu_en), .o_periph_clk_en(per_en),
    .o_main_osc_en(osc_en), .o_main_osc_freq(freq), .o_periph_tick(ptick), .o_power_mode(mode),
    .o_chip_reset(chip_rst), .o_irq(irq));
  pwr_clk_partner model_u (.i_sys_clk(clk), .i_main_osc_en(osc_en), .o_main_osc(m_o),
    .o_slow_osc(s_o), .o_watch_osc(w_o), .o_ext_clk(e_o));
  // clock and chip reset tally
  initial begin
    forever #25 clk = ~clk;
  end
  always @(posedge clk) if (chip_rst === 1'b1) n_rst++;
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      $display("ERROR %s exp %h got %h", nm, exp, got);
      n_errors++;
    end
  endtask : chk
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] dat);
    int k;
    @(posedge clk);
    rd <= !w;
    wr <= w;
    addr <= a;
    wdata <= dat;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (wreq !== 1'b0 && k < 20);
    q = o_rd;
    rd <= 1'b0;
    wr <= 1'b0;
    if (k == 20) chk("bus", 0, 1);
  endtask : bus
  task automatic cnt(input int c, input int k);
    nh = 0;
    np = 0;
    nl = 0;
    repeat (c) begin
      @(posedge clk);
      nh += int'(hf === 1'b1);
      nl += int'(lf === 1'b1);
      np += int'(ptick[k] === 1'b1);
    end
  endtask : cnt
  task automatic finish_test();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : finish_test
  // watchdog on a hung run
  initial begin
    #(50 * 20000);
    n_errors++;
    finish_test();
  end
  // main sequence
  initial begin
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    por_nrst <= 1'b1;
    repeat (8) @(posedge clk);
    for (int i = 0; i < 7; i++) begin
      bus(1'b0, row_a[i], 32'h0000_0000);
      chk("reset value", row_d[i], q);
    end
    chk("freq pin", 0, freq);
    $display("reset values done");
    bus(1'b1, ADDR_PWR_CTRL, 32'(MODE_SLEEP));
    cnt(4, 0);
    chk("sleep", {2'(MODE_SLEEP), 1'b0, 1'b1}, {mode, cpu_en, per_en});
    wake <= 1'b1;
    cnt(8, 0);
    wake <= 1'b0;
    chk("sleep wake", {2'(MODE_ACTIVE), 1'b1, 1'b1}, {mode, cpu_en, per_en});
    bus(1'b1, ADDR_PWR_CTRL, 32'(MODE_DEEP));
    cnt(40, 0);
    chk("deep", {2'(MODE_DEEP), 1'b0}, {mode, osc_en});
    chk("slow tick in deep", 1, nl >= 2);
    wake <= 1'b1;
    n = 0;
    while (mode !== MODE_ACTIVE && n < 900) begin
      @(posedge clk);
      n++;
    end
    wake <= 1'b0;
    chk("deep wake", 1, n >= WAKE_CYC && n <= WAKE_CYC + 8);
    supply_ok <= 1'b0;
    cnt(8, 0);
    chk("no supply", 0, cpu_en);
    supply_ok <= 1'b1;
    cnt(8, 0);
    chk("supply back", 1, cpu_en);
    $display("power modes done");
    bus(1'b1, ADDR_MAIN_FREQ, 32'h0000_0006);
    bus(1'b1, ADDR_MAIN_FREQ, 32'h0000_0007);
    bus(1'b0, ADDR_MAIN_FREQ, 32'h0000_0000);
    chk("freq", 32'h0000_0006, q);
    chk("freq pin", 6, freq);
    bus(1'b1, ADDR_INT_STAT, 32'h0000_0000);
    for (int s = 1; s < 5; s++) begin
      bus(1'b1, ADDR_INT_MASK, (s == 4) ? 32'h0000_0000 : 32'h0000_0004);
      bus(1'b1, ADDR_CLK_SEL, 32'(s % 4));
      cnt(70, 0);
      chk("irq", s != 4, irq);
      cnt(80, 0);
      chk("ticks", 1, nh > 0);
      bus(1'b0, ADDR_INT_STAT, 32'h0000_0000);
      chk("switched", 1, q[INT_CLK_SW]);
      cnt(2, 0);
      chk("irq clear", 0, irq);
    end
    $display("clock sources done");
    for (int k = 0; k < 8; k++) begin
      bus(1'b1, ADDR_DIV_BASE + 8'(4 * k), 32'h8000_0000 | 32'(k));
      cnt(400, k);
      d = nh - np * (k + 1);
      chk("divider", 1, np > 0 && d >= -(k + 1) && d <= k + 1);
    end
    bus(1'b1, ADDR_DIV_BASE, 32'h8000_0000 | (32'h0000_0010 << DIV_FRAC_LSB));
    cnt(400, 0);
    d = 2 * nh - 3 * np;
    chk("fraction", 1, np > 0 && d >= -6 && d <= 6);
    $display("dividers done");
    bus(1'b1, ADDR_SUP_SERVICE, SUP_KEY);
    bus(1'b1, ADDR_SUP_MATCH, 32'h0000_0003);
    n = n_rst;
    repeat (30) bus(1'b1, ADDR_SUP_SERVICE, SUP_KEY);
    chk("serviced", n, n_rst);
    bus(1'b1, ADDR_SUP_SERVICE, 32'h0000_0000);
    cnt(100, 0);
    chk("timeout", 1, n_rst > n);
    bus(1'b1, ADDR_SUP_CTRL, 32'h0000_0000);
    nrst <= 1'b0;
    cnt(3, 0);
    nrst <= 1'b1;
    cnt(8, 0);
    bus(1'b0, ADDR_RST_CAUSE, 32'h0000_0000);
    chk("cause kept", 1, q[CAUSE_SUP]);
    brownout <= 1'b1;
    cnt(10, 0);
    brownout <= 1'b0;
    cnt(10, 0);
    bus(1'b0, ADDR_RST_CAUSE, 32'h0000_0000);
    chk("brown-out cause", 1, q[CAUSE_BOD]);
    bus(1'b1, ADDR_RST_CAUSE, 32'h0000_0003);
    bus(1'b0, ADDR_RST_CAUSE, 32'h0000_0000);
    chk("cause clear", 0, q[CAUSE_W-1:0]);
    $display("supervision done");
    finish_test();
  end
endmodule : power_clock_watchdog_ctrl_test

//--- tb/pwr_clk_ctrl_monitor.sv
// port assertions of the controller
`timescale 1ns/1ns
module pwr_clk_ctrl_monitor
  import pwr_clk_pkg::*;
(
  input wire logic       i_sys_clk,
  input wire logic       i_nrst,
  input wire logic       i_avs_read,
  input wire logic       i_avs_write,
  input wire logic       o_avs_waitrequest,
  input wire logic       i_supply_ok,
  input wire logic       i_brownout,
  input wire logic       o_hf_tick,
  input wire logic       o_cpu_clk_en,
  input wire logic       o_periph_clk_en,
  input wire logic       o_main_osc_en,
  input wire logic [2:0] o_main_osc_freq,
  input wire logic [1:0] o_power_mode,
  input wire logic       o_chip_reset
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_nrst);
  int wake_cnt;
  // cycles spent waking
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) wake_cnt <= 0;
    else wake_cnt <= (o_power_mode == MODE_WAKING) ? wake_cnt + 1 : 0;
  end
  sequence s_req; (i_avs_read || i_avs_write) && o_avs_waitrequest; endsequence
  sequence s_ack; !o_avs_waitrequest ##1 o_avs_waitrequest; endsequence
  AST_ONE_WAIT: assert property (s_req |=> s_ack)
    else $error("bus answer not one cycle");
  AST_CPU_ACTIVE: assert property (o_cpu_clk_en |-> o_power_mode == MODE_ACTIVE)
    else $error("cpu clock outside active");
  AST_SLEEP_GATE: assert property (o_power_mode == MODE_SLEEP |-> o_periph_clk_en)
    else $error("peripherals stopped in sleep");
  AST_DEEP_OFF: assert property (o_power_mode == MODE_DEEP |-> !o_main_osc_en && !o_hf_tick)
    else $error("fast clock alive in deep sleep");
  AST_WAKE_TIME: assert property ($fell(o_power_mode == MODE_WAKING) &&
    o_power_mode == MODE_ACTIVE |-> wake_cnt == WAKE_CYC)
    else $error("wake time wrong");
  AST_FREQ_RANGE: assert property (o_main_osc_freq <= MAIN_FREQ_MAX)
    else $error("main frequency code out of range");
  AST_SUPPLY_HOLD: assert property (!i_supply_ok [*6] |-> !o_cpu_clk_en && !o_periph_clk_en)
    else $error("mode held without supply");
  AST_BROWNOUT: assert property ($rose(i_brownout) |-> ##[1:8] o_chip_reset)
    else $error("no reset on brown-out");
  AST_RST_PULSE: assert property (o_chip_reset |=> !o_chip_reset)
    else $error("chip reset longer than one cycle");
endmodule : pwr_clk_ctrl_monitor
bind pwr_clk_ctrl pwr_clk_ctrl_monitor mon_u (.i_sys_clk, .i_nrst, .i_avs_read, .i_avs_write,
  .o_avs_waitrequest, .i_supply_ok, .i_brownout, .o_hf_tick, .o_cpu_clk_en,
  .o_periph_clk_en, .o_main_osc_en, .o_main_osc_freq, .o_power_mode, .o_chip_reset);

//--- tb/pwr_clk_partner.sv
// oscillator pins feeding the controller
`timescale 1ns/1ns
module pwr_clk_partner (
  input  wire logic i_sys_clk,
  input  wire logic i_main_osc_en,
  output logic      o_main_osc,
  output logic      o_slow_osc,
  output logic      o_watch_osc,
  output logic      o_ext_clk
);
  logic [7:0] cnt = 8'h00;
  // free-running phase counter
  always @(posedge i_sys_clk) begin
    cnt <= cnt + 8'h01;
  end
  assign o_slow_osc  = cnt[3];
  assign o_watch_osc = cnt[2];
  assign o_ext_clk   = cnt[1] ^ cnt[2];
  assign o_main_osc  = i_main_osc_en & cnt[1];
endmodule : pwr_clk_partner
